// ---- core/tx_ctrl_pkg.sv ----
// Shared constants and types for the transmitter control block
package tx_ctrl_pkg;

  // ==========================================================
  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BAND_OFS = 8'h04;
  localparam logic [7:0] WHOLE_OFS = 8'h08;
  localparam logic [7:0] FINE_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] RATIO_OFS = 8'h14;

  // ==========================================================
  // Field positions
  localparam int LOCK_BIT = 0;
  localparam int LOWSUP_BIT = 1;
  localparam int SLEEP_BIT = 2;
  localparam int SEL_LSB = 3;
  localparam int SRC_LSB = 5;
  localparam int PSC_LSB = 7;
  localparam int BAND_LSB = 0;
  localparam int REF_DIVIDER_LSB = 2;
  localparam int WHOLE_MOD_BIT = 9;
  localparam int WHOLE_DBL_BIT = 8;
  localparam int WHOLE_AC_LSB = 4;

  // ==========================================================
  // Values after reset and defaults
  localparam logic [1:0] SEL_DEF = 2'h3;
  localparam logic [1:0] SRC_DEF = 2'h0;
  localparam logic [2:0] PSC_DEF = 3'h4;
  localparam logic [1:0] BAND_RST = 2'h0;
  localparam logic [2:0] REF_DIVIDER_RST = 3'h2;
  localparam logic [9:0] WHOLE_RST = 10'h000;
  localparam logic [15:0] FINE_RST = 16'h0000;

  // ==========================================================
  // Synthesizer arithmetic
  localparam logic [2:0] MOD_BASE = 3'h4;
  localparam logic [4:0] N_BASE = 5'h0A;
  localparam logic [4:0] N_DBL_STEP = 5'h06;
  localparam logic [4:0] AC_STEP = 5'h03;
  localparam logic [3:0] REF_DIVIDER_BASE = 4'h2;

  // ==========================================================
  // Codes and states
  localparam logic [1:0] SRC_PRESC = 2'h0;
  localparam logic [1:0] SRC_BAUD = 2'h1;
  localparam logic [1:0] SRC_BAUD_INV = 2'h2;
  localparam logic [1:0] SEL_TX_ONLY = 2'h2;
  localparam logic [1:0] SEL_ALWAYS = 2'h3;

  typedef enum logic [1:0] {
    PWR_DOWN,
    PWR_IDLE,
    PWR_TX
  } pwr_state_t;

endpackage

// ---- core/synth_decode.sv ----
// Decoding of band, reference divider and synthesizer words into counter values
`timescale 1ns/100ps
`default_nettype none
module synth_decode
(
  input wire logic [1:0] band_select,
  input wire logic [2:0] ref_divider,
  input wire logic [9:0] whole_word,
  input wire logic [15:0] fine_word,
  output logic [1:0] predivider,
  output logic [2:0] modulus,
  output logic [4:0] n_count,
  output logic [4:0] a_count,
  output logic [16:0] frac_part,
  output logic [3:0] ref_ratio
);
  import tx_ctrl_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic [4:0] widen4(input logic [3:0] v);
    widen4 = {1'b0, v};
  endfunction

  function automatic logic [4:0] scale_dbl(input logic dbl, input logic [4:0] step);
    scale_dbl = dbl ? 5'(step << 1) : step;
  endfunction

  // ==========================================================
  // Counter values
  logic dbl;
  assign dbl = whole_word[WHOLE_DBL_BIT];
  assign predivider = band_select[1] ? 2'h2 : 2'h1;
  assign modulus = MOD_BASE + {2'h0, whole_word[WHOLE_MOD_BIT]};
  assign n_count = widen4(whole_word[3:0]) + (dbl ? N_DBL_STEP : 5'h00) + N_BASE;
  assign a_count = widen4(whole_word[7:4]) + 5'h01 + scale_dbl(dbl, AC_STEP);
  // Fraction in units of 2^-16; doubling widens the fractional reach
  assign frac_part = dbl ? {fine_word, 1'b0} : {1'b0, fine_word};
  assign ref_ratio = {1'b0, ref_divider} + REF_DIVIDER_BASE;

endmodule
`default_nettype wire

// ---- core/host_clock_gen.sv ----
// Host clock output generator with prescaler and source selection
`timescale 1ns/100ps
`default_nettype none
module host_clock_gen
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic run,
  input wire logic tx_active,
  input wire logic baud_in,
  input wire logic [1:0] out_select,
  input wire logic [1:0] source,
  input wire logic [2:0] prescale_exp,
  output logic clk_out,
  output logic clk_oe
);
  import tx_ctrl_pkg::*;

  // ==========================================================
  // Prescaler
  logic [6:0] cnt;
  logic [2:0] psc_act;
  logic presc_q;
  logic [6:0] term;

  // Exponent 0 cannot come from a flop; it runs at divide by two
  assign term = (psc_act == 3'h0) ? 7'h00 : 7'((7'h01 << (psc_act - 3'h1)) - 7'h01);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 7'h00;
      presc_q <= 1'b0;
      psc_act <= PSC_DEF;
    end else if (ce) begin
      if (!run) begin
        cnt <= 7'h00;
        presc_q <= 1'b0;
        psc_act <= prescale_exp;
      end else if (cnt >= term) begin
        cnt <= 7'h00;
        presc_q <= ~presc_q;
        // While running, new ratio is taken only at the low-going phase to avoid runt periods
        if (presc_q) begin
          psc_act <= prescale_exp;
        end
      end else begin
        cnt <= cnt + 7'h01;
      end
    end
  end

  // ==========================================================
  // Output selection
  logic enable;
  logic src_val;
  assign enable = run && (out_select == SEL_ALWAYS || (out_select == SEL_TX_ONLY && tx_active));

  always_comb begin
    case (source)
      SRC_PRESC: src_val = presc_q;
      SRC_BAUD: src_val = baud_in;
      SRC_BAUD_INV: src_val = ~baud_in;
      default: src_val = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clk_out <= 1'b0;
      clk_oe <= 1'b0;
    end else if (ce) begin
      clk_out <= enable ? src_val : 1'b0;
      clk_oe <= enable;
    end
  end

endmodule
`default_nettype wire

// ---- core/tx_control_synth_config.sv ----
// Transmitter control: lock, low supply, sleep, host clock and synthesizer setup
//
// Function
// - Entering power-down sets transmit lock.
// - Lock set keeps amplifier off, commands accepted.
// - Write in power-down wakes to inactive state.
// - Low supply during transmit sets lock.
// - Low supply sets readable, writable indicator flag.
// - Wake samples data pin: high keeps selection.
// - Default clock selection 11, always driving.
// - Clock source: prescaler or baud output.
// - Prescaler divides by two to exponent; exponent 0 also divides by two.
// - Wake with pin low restores clock defaults.
// - Writing force-sleep enters power-down one cycle after the write is taken.
// - Power-down clears force-sleep bit.
// - Band select bit 1 sets predivider.
// - Reference ratio is divider field plus two.
// - Modulus is whole bit 9 plus four.
// - N equals low nibble, six times bit8, ten.
// - A offset: nibble plus one, three times.
// - Fraction is fine word scaled by bit8.
// - Bit 8 doubles modulator output range.
// - Low-supply flag resets to zero, active high.
// - Force-sleep resets to zero, active high.
`timescale 1ns/100ps
`default_nettype none
module tx_control_synth_config
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [tx_ctrl_pkg::ADDR_W-1:0] addr,
  input wire logic [tx_ctrl_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [tx_ctrl_pkg::DATA_W-1:0] rdata,
  input wire logic tx_start,
  input wire logic tx_stop,
  input wire logic pa_supply_low,
  input wire logic serial_data_pin,
  input wire logic baud_clk,
  output logic pa_enable,
  output logic power_down,
  output logic host_clock_pin_o,
  output logic host_clock_pin_oe,
  output logic [1:0] predivider,
  output logic [2:0] modulus,
  output logic [4:0] n_count,
  output logic [4:0] a_count,
  output logic [16:0] frac_part,
  output logic [3:0] ref_ratio
);
  import tx_ctrl_pkg::*;

  // ==========================================================
  // Declarations
  pwr_state_t state;
  pwr_state_t next_state;
  logic tx_lock;
  logic low_supply_flag;
  logic force_sleep;
  logic [1:0] host_clock_out_select;
  logic [1:0] host_clock_source;
  logic [2:0] clock_prescale_exp;
  logic [1:0] band_select;
  logic [2:0] ref_divider;
  logic [9:0] whole_word;
  logic [15:0] fine_word;
  logic woke_by_write;
  logic defaults_restored;
  logic wr_ctrl;
  logic wr_band;
  logic wr_whole;
  logic wr_fine;
  logic wake;
  logic restore;
  logic enter_down;
  logic [1:0] dec_p;
  logic [2:0] dec_m;
  logic [4:0] dec_n;
  logic [4:0] dec_a;
  logic [16:0] dec_frac;
  logic [3:0] dec_ratio;
  logic clk_o;
  logic clk_oe;

  // ==========================================================
  // Decode
  assign wr_ctrl = wr && (addr == CTRL_OFS);
  assign wr_band = wr && (addr == BAND_OFS);
  assign wr_whole = wr && (addr == WHOLE_OFS);
  assign wr_fine = wr && (addr == FINE_OFS);
  // Any write while asleep wakes the device
  assign wake = wr && (state == PWR_DOWN);
  // Pin low on wake restores the clock defaults
  assign restore = wake && !serial_data_pin;
  assign enter_down = (next_state == PWR_DOWN) && (state != PWR_DOWN);

  // ==========================================================
  // Power state
  always_comb begin
    next_state = state;
    case (state)
      PWR_DOWN: begin
        if (wake) begin
          next_state = PWR_IDLE;
        end
      end
      PWR_IDLE: begin
        if (force_sleep) begin
          next_state = PWR_DOWN;
        end else if (tx_start) begin
          next_state = PWR_TX;
        end
      end
      PWR_TX: begin
        if (force_sleep) begin
          next_state = PWR_DOWN;
        end else if (tx_stop) begin
          next_state = PWR_IDLE;
        end
      end
      default: next_state = PWR_DOWN;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= PWR_DOWN;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Transmit lock
  // Hardware sets win over a software clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_lock <= 1'b1;
    end else if (ce) begin
      if (enter_down || state == PWR_DOWN) begin
        tx_lock <= 1'b1;
      end else if (state == PWR_TX && pa_supply_low) begin
        tx_lock <= 1'b1;
      end else if (wr_ctrl) begin
        tx_lock <= wdata[LOCK_BIT];
      end
    end
  end

  // ==========================================================
  // Low-supply indicator
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_supply_flag <= 1'b0;
    end else if (ce) begin
      if (pa_supply_low) begin
        low_supply_flag <= 1'b1;
      end else if (wr_ctrl) begin
        low_supply_flag <= wdata[LOWSUP_BIT];
      end
    end
  end

  // ==========================================================
  // Force sleep
  // Clear wins while asleep so a wake write cannot lock the device down
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      force_sleep <= 1'b0;
    end else if (ce) begin
      if (state == PWR_DOWN) begin
        force_sleep <= 1'b0;
      end else if (wr_ctrl) begin
        force_sleep <= wdata[SLEEP_BIT];
      end
    end
  end

  // ==========================================================
  // Host clock fields
  // Restoring defaults wins over the waking write itself
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      host_clock_out_select <= SEL_DEF;
      host_clock_source <= SRC_DEF;
      clock_prescale_exp <= PSC_DEF;
    end else if (ce) begin
      if (restore) begin
        host_clock_out_select <= SEL_DEF;
        host_clock_source <= SRC_DEF;
        clock_prescale_exp <= PSC_DEF;
      end else if (wr_ctrl) begin
        host_clock_out_select <= wdata[SEL_LSB +: 2];
        host_clock_source <= wdata[SRC_LSB +: 2];
        clock_prescale_exp <= wdata[PSC_LSB +: 3];
      end
    end
  end

  // ==========================================================
  // Wake status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      woke_by_write <= 1'b0;
      defaults_restored <= 1'b0;
    end else if (ce) begin
      if (wake) begin
        woke_by_write <= 1'b1;
        defaults_restored <= restore;
      end else if (enter_down) begin
        woke_by_write <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Synthesizer words
  // Range limits on N and A are the host's duty and are not checked
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      band_select <= BAND_RST;
      ref_divider <= REF_DIVIDER_RST;
    end else if (ce && wr_band) begin
      band_select <= wdata[BAND_LSB +: 2];
      ref_divider <= wdata[REF_DIVIDER_LSB +: 3];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      whole_word <= WHOLE_RST;
    end else if (ce && wr_whole) begin
      whole_word <= wdata[9:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fine_word <= FINE_RST;
    end else if (ce && wr_fine) begin
      fine_word <= wdata;
    end
  end

  synth_decode u_decode (
    .band_select(band_select),
    .ref_divider(ref_divider),
    .whole_word(whole_word),
    .fine_word(fine_word),
    .predivider(dec_p),
    .modulus(dec_m),
    .n_count(dec_n),
    .a_count(dec_a),
    .frac_part(dec_frac),
    .ref_ratio(dec_ratio)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      predivider <= 2'h1;
      modulus <= MOD_BASE;
      n_count <= N_BASE;
      a_count <= 5'h04;
      frac_part <= 17'h00000;
      ref_ratio <= 4'h4;
    end else if (ce) begin
      predivider <= dec_p;
      modulus <= dec_m;
      n_count <= dec_n;
      a_count <= dec_a;
      frac_part <= dec_frac;
      ref_ratio <= dec_ratio;
    end
  end

  // ==========================================================
  // Host clock pin
  host_clock_gen u_clk (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .run(state != PWR_DOWN),
    .tx_active(state == PWR_TX),
    .baud_in(baud_clk),
    .out_select(host_clock_out_select),
    .source(host_clock_source),
    .prescale_exp(clock_prescale_exp),
    .clk_out(clk_o),
    .clk_oe(clk_oe)
  );

  assign host_clock_pin_o = clk_o;
  assign host_clock_pin_oe = clk_oe;

  // ==========================================================
  // Power outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pa_enable <= 1'b0;
      power_down <= 1'b1;
    end else if (ce) begin
      // Commands still move the state; only the amplifier is held off
      pa_enable <= (next_state == PWR_TX) && !tx_lock && !(pa_supply_low && state == PWR_TX);
      power_down <= (next_state == PWR_DOWN);
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      rdata <= 16'h0000;
      if (rd) begin
        case (addr)
          CTRL_OFS: begin
            rdata[LOCK_BIT] <= tx_lock;
            rdata[LOWSUP_BIT] <= low_supply_flag;
            rdata[SLEEP_BIT] <= force_sleep;
            rdata[SEL_LSB +: 2] <= host_clock_out_select;
            rdata[SRC_LSB +: 2] <= host_clock_source;
            rdata[PSC_LSB +: 3] <= clock_prescale_exp;
          end
          BAND_OFS: begin
            rdata[BAND_LSB +: 2] <= band_select;
            rdata[REF_DIVIDER_LSB +: 3] <= ref_divider;
          end
          WHOLE_OFS: rdata[9:0] <= whole_word;
          FINE_OFS: rdata <= fine_word;
          STAT_OFS: begin
            rdata[1:0] <= state;
            rdata[2] <= pa_enable;
            rdata[3] <= clk_oe;
            rdata[7:4] <= ref_ratio;
            rdata[8] <= woke_by_write;
            rdata[9] <= defaults_restored;
          end
          RATIO_OFS: begin
            rdata[4:0] <= n_count;
            rdata[9:5] <= a_count;
            rdata[12:10] <= modulus;
            rdata[14:13] <= predivider;
          end
          default: rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- dv/tx_ctrl_assertions.sv ----
// Concurrent checks on the transmitter control block ports
`timescale 1ns/100ps
`default_nettype none
module tx_ctrl_checker
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [tx_ctrl_pkg::ADDR_W-1:0] addr,
  input wire logic [tx_ctrl_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [tx_ctrl_pkg::DATA_W-1:0] rdata,
  input wire logic pa_supply_low,
  input wire logic pa_enable,
  input wire logic power_down,
  input wire logic host_clock_pin_oe,
  input wire logic [1:0] predivider,
  input wire logic [2:0] modulus,
  input wire logic [4:0] n_count,
  input wire logic [4:0] a_count,
  input wire logic [3:0] ref_ratio
);
  import tx_ctrl_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Sequences
  sequence seq_sleep_req;
    ce && wr && addr == CTRL_OFS && wdata[SLEEP_BIT] && !power_down;
  endsequence
  sequence seq_ratio_read;
    ce && rd && addr == RATIO_OFS ##1 ($stable(n_count) && $stable(a_count));
  endsequence
  // ==========================================================
  // Power and transmit
  chk_pd_pa_off: assert property (power_down |-> !pa_enable)
    else $error("amplifier on in power-down");
  chk_sleep_entry: assert property (seq_sleep_req |-> ##[1:3] power_down)
    else $error("forced sleep not entered");
  chk_wake_write: assert property (ce && wr && power_down |=> !power_down)
    else $error("write did not wake");
  chk_supply_cut: assert property (ce && pa_supply_low && pa_enable |=> !pa_enable)
    else $error("amplifier kept on at low supply");
  chk_stat_pa: assert property (ce && rd && addr == STAT_OFS ##1 $stable(pa_enable) |-> rdata[2] == pa_enable)
    else $error("status amplifier bit wrong");
  // Pin lags by one cycle, so only a settled power-down is judged
  chk_clock_pd: assert property (power_down [*3] |-> !host_clock_pin_oe)
    else $error("host clock driven in power-down");
  // ==========================================================
  // Synthesizer
  chk_ratio_read: assert property (seq_ratio_read |-> rdata[4:0] == n_count && rdata[9:5] == a_count)
    else $error("ratio readback differs from counters");
  chk_band_range: assert property ((modulus == 3'h4 || modulus == 3'h5) && (predivider == 2'h1 || predivider == 2'h2))
    else $error("modulus or predivider out of range");
  chk_ref_range: assert property (ref_ratio >= 4'h2 && ref_ratio <= 4'h9)
    else $error("reference ratio out of range");
endmodule
bind tx_control_synth_config tx_ctrl_checker u_chk (.ref_clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata,
  .pa_supply_low, .pa_enable, .power_down, .host_clock_pin_oe, .predivider, .modulus, .n_count, .a_count,
  .ref_ratio);
`default_nettype wire

// ---- dv/host_model.sv ----
// Host controller model: register port master and data pin
`timescale 1ns/100ps
`default_nettype none
module host_model
(
  input wire logic ref_clk,
  output logic [tx_ctrl_pkg::ADDR_W-1:0] addr,
  output logic [tx_ctrl_pkg::DATA_W-1:0] wdata,
  output logic wr,
  output logic rd,
  output logic serial_data_pin
);
  import tx_ctrl_pkg::*;
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    serial_data_pin = 1'b1;
  end
  // One-cycle strobe; data inverted on release so stale values never look valid
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge ref_clk);
    wr <= 1'b0;
    rd <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic pin(input logic v);
    @(posedge ref_clk);
    serial_data_pin <= v;
  endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the transmitter control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import tx_ctrl_pkg::*;
  logic ref_clk = 1'b0, rst, ce, tx_start, tx_stop, pa_supply_low, baud_clk, serial_data_pin;
  logic wr, rd, pa_enable, power_down, host_clock_pin_o, host_clock_pin_oe, rd_q = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  logic [1:0] predivider, b, ep;
  logic [2:0] modulus, dv;
  logic [4:0] n_count, a_count, en, ea;
  logic [16:0] frac_part;
  logic [3:0] ref_ratio;
  logic [9:0] w;
  logic bq;
  logic [15:0] f;
  logic [31:0] r;
  logic [15:0] exp_q[$];
  int n_errors = 0, checked = 0, seed = 99, k, n;

  always #2.5 ref_clk = ~ref_clk;
  always begin
    repeat (3) @(posedge ref_clk);
    baud_clk <= ~baud_clk;
  end

  host_model u_host (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .serial_data_pin(serial_data_pin));
  tx_control_synth_config u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .tx_start(tx_start), .tx_stop(tx_stop), .pa_supply_low(pa_supply_low),
    .serial_data_pin(serial_data_pin), .baud_clk(baud_clk), .pa_enable(pa_enable), .power_down(power_down),
    .host_clock_pin_o(host_clock_pin_o), .host_clock_pin_oe(host_clock_pin_oe), .predivider(predivider),
    .modulus(modulus), .n_count(n_count), .a_count(a_count), .frac_part(frac_part), .ref_ratio(ref_ratio));

  // ==========================================================
  // Checking
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    rd_q <= rd;
    if (rd_q) begin
      if (exp_q.size() == 0) check("read queue", 0, 1);
      else check("rdata", rdata, exp_q.pop_front());
    end
  end
  task automatic rdx(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.bus(1'b0, a, 16'h0000);
  endtask
  task automatic pulse(input logic stop);
    @(posedge ref_clk);
    tx_start <= !stop;
    tx_stop <= stop;
    @(posedge ref_clk);
    tx_start <= 1'b0;
    tx_stop <= 1'b0;
  endtask
  // Bounded: no second rising edge leaves n at -1
  task automatic measure(output int p);
    int i, t0;
    logic prev;
    p = -1;
    t0 = -1;
    prev = host_clock_pin_o;
    for (i = 0; i < 120 && p < 0; i++) begin
      @(posedge ref_clk);
      if (host_clock_pin_o === 1'b1 && prev === 1'b0) begin
        if (t0 >= 0) p = i - t0;
        t0 = i;
      end
      prev = host_clock_pin_o;
    end
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end

  // ==========================================================
  // Scenarios
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    tx_start = 1'b0;
    tx_stop = 1'b0;
    pa_supply_low = 1'b0;
    baud_clk = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rdx(CTRL_OFS, 16'h0219);
    rdx(STAT_OFS, 16'h0040);
    rdx(RATIO_OFS, 16'h308A);
    $display("test reset done");
    u_host.pin(1'b1);
    u_host.bus(1'b1, CTRL_OFS, 16'h0131);
    rdx(CTRL_OFS, 16'h0131);
    rdx(STAT_OFS, 16'h0141);
    pulse(1'b0);
    repeat (3) @(posedge ref_clk);
    check("pa locked", pa_enable, 1'b0);
    rdx(STAT_OFS, 16'h014A);
    pulse(1'b1);
    u_host.bus(1'b1, CTRL_OFS, 16'h0130);
    pulse(1'b0);
    repeat (3) @(posedge ref_clk);
    check("pa on", pa_enable, 1'b1);
    pa_supply_low <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("pa cut", pa_enable, 1'b0);
    rdx(CTRL_OFS, 16'h0133);
    pa_supply_low <= 1'b0;
    u_host.bus(1'b1, CTRL_OFS, 16'h0130);
    rdx(CTRL_OFS, 16'h0130);
    u_host.bus(1'b1, CTRL_OFS, 16'h0132);
    rdx(CTRL_OFS, 16'h0132);
    $display("test lock and supply done");
    u_host.bus(1'b1, CTRL_OFS, 16'h0134);
    repeat (3) @(posedge ref_clk);
    check("power_down", power_down, 1'b1);
    rdx(CTRL_OFS, 16'h0131);
    u_host.pin(1'b0);
    u_host.bus(1'b1, CTRL_OFS, 16'h0001);
    u_host.pin(1'b1);
    rdx(CTRL_OFS, 16'h0219);
    rdx(STAT_OFS, 16'h0349);
    $display("test sleep and wake done");
    for (k = 4; k < 9; k++) begin
      if (k < 7) u_host.bus(1'b1, CTRL_OFS, 16'h0019 | (16'((k == 4) ? 4 : (k & 3)) << 7));
      else u_host.bus(1'b1, CTRL_OFS, (k == 7) ? 16'h0239 : 16'h0259);
      repeat (40) @(posedge ref_clk);
      measure(n);
      check("clock period", n, (k == 4) ? 16 : (k > 6) ? 6 : (1 << (k & 3)));
      if (k > 6) begin
        bq = baud_clk;
        @(posedge ref_clk);
        check("clock phase", host_clock_pin_o, bq ^ (k == 8));
      end
    end
    $display("test host clock done");
    for (k = 0; k < 8; k++) begin
      r = $random(seed);
      b = k[1:0];
      w = r[9:0];
      dv = r[12:10];
      f = r[31:16];
      w[9] = (b != 2'h0);
      if (!w[8]) begin
        w[3:0] = w[3:0] | 4'h2;
        w[7:4] = w[7:4] % (w[3:0] - 4'h1);
      end
      u_host.bus(1'b1, BAND_OFS, {11'h000, dv, b});
      u_host.bus(1'b1, WHOLE_OFS, {6'h00, w});
      u_host.bus(1'b1, FINE_OFS, f);
      repeat (3) @(posedge ref_clk);
      ep = b[1] ? 2'h2 : 2'h1;
      en = {1'b0, w[3:0]} + (w[8] ? 5'h10 : 5'h0A);
      ea = {1'b0, w[7:4]} + (w[8] ? 5'h07 : 5'h04);
      check("predivider", predivider, ep);
      check("modulus", modulus, {2'h0, w[9]} + 3'h4);
      check("n_count", n_count, en);
      check("a_count", a_count, ea);
      check("frac_part", frac_part, w[8] ? {f, 1'b0} : {1'b0, f});
      check("ref_ratio", ref_ratio, {1'b0, dv} + 4'h2);
      rdx(RATIO_OFS, {1'b0, ep, {2'h0, w[9]} + 3'h4, ea, en});
    end
    // Enable low must swallow a write
    ce <= 1'b0;
    u_host.bus(1'b1, FINE_OFS, ~f);
    @(posedge ref_clk);
    ce <= 1'b1;
    rdx(FINE_OFS, f);
    $display("test synthesizer done");
    repeat (2) @(posedge ref_clk);
    check("queue drained", exp_q.size(), 0);
    summarize();
  end
endmodule
`default_nettype wire
